// ---- common/ats_consts.svh ----
// Offsets, field positions, opcodes, reset values and counts of the security lock core
`ifndef ATS_CONSTS_SVH
`define ATS_CONSTS_SVH

// Command opcodes handled by the core
`define ATS_OP_SET_PW   8'hF1
`define ATS_OP_UNLOCK   8'hF2
`define ATS_OP_PREPARE  8'hF3
`define ATS_OP_ERASE    8'hF4
`define ATS_OP_FREEZE   8'hF5
`define ATS_OP_DISABLE  8'hF6

// Password sector layout
`define ATS_CW_ID_BIT    0
`define ATS_CW_LEVEL_BIT 8
`define ATS_PW_FIRST     8'h01
`define ATS_PW_LAST      8'h10
`define ATS_SECTOR_LAST  8'hFF

// Failed-unlock budget after power-on or hardware reset
`define ATS_ATTEMPTS_INIT 3'h5

// Register map (byte addresses)
`define ATS_REG_CTRL   4'h0
`define ATS_REG_STATUS 4'h4

// Control register fields and reset values
`define ATS_CTRL_SUPPORTED_BIT 0
`define ATS_CTRL_RESET         1'h1

// Status register fields
`define ATS_ST_LOCKED_BIT  0
`define ATS_ST_FROZEN_BIT  1
`define ATS_ST_LEVEL_BIT   2
`define ATS_ST_LOCKEN_BIT  3
`define ATS_ST_ATT_LSB     4
`define ATS_ST_ARMED_BIT   7
`define ATS_ST_BUSY_BIT    8
`define ATS_ST_USERPW_BIT  9

// Sector count value written back after freeze
`define ATS_SECCNT_FROZEN 8'h00

`endif

// ---- common/ats_pkg.sv ----
// Types shared by the security lock core and its password store
package ats_pkg;
  typedef logic [15:0] ats_word_t;
  typedef logic [3:0]  ats_pw_idx_t;

  // Command sequencer states, one-hot
  typedef enum logic [2:0] {
    ATS_IDLE = 3'b001,
    ATS_RECV = 3'b010,
    ATS_FIN  = 3'b100
  } ats_state_e;
endpackage

// ---- common/ats_pw_if.sv ----
// Port between the lock core and the password store
interface ats_pw_if;
  import ats_pkg::*;
  logic        wr_en;
  logic        wr_sel;
  ats_pw_idx_t wr_idx;
  ats_word_t   wr_data;
  logic        rd_sel;
  ats_pw_idx_t rd_idx;
  ats_word_t   rd_data;

  modport core (output wr_en, output wr_sel, output wr_idx, output wr_data,
                output rd_sel, output rd_idx, input rd_data);
  modport mem  (input wr_en, input wr_sel, input wr_idx, input wr_data,
                input rd_sel, input rd_idx, output rd_data);
endinterface

// ---- design/ats_pw_mem.sv ----
// Password store: user slot 0, master slot 1, sixteen words each
module ats_pw_mem
  import ats_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  ats_pw_if.mem    pw
);
  ats_word_t mem_q [0:31];
  ats_word_t rd_reg;

  // Power-on leaves both passwords all zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 32; i++) begin
        mem_q[i] <= 16'h0000;
      end
    end else if (pw.wr_en) begin
      mem_q[{pw.wr_sel, pw.wr_idx}] <= pw.wr_data;
    end
  end

  // Registered read port, one cycle latency
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_reg <= 16'h0000;
    end else begin
      rd_reg <= mem_q[{pw.rd_sel, pw.rd_idx}];
    end
  end

  assign pw.rd_data = rd_reg;
endmodule

// ---- design/ats_lock_core.sv ----
// Security lock command core: passwords, lock, freeze and unlock attempts
module ats_lock_core
  import ats_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hw_reset_pin,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        data_valid,
  input  wire logic [15:0] data_word,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  output logic             data_req,
  output logic             cmd_done,
  output logic             cmd_abort,
  output logic             seccnt_wr,
  output logic      [7:0]  seccnt_val,
  output logic             erase_start,
  output logic             wear_level_start,
  output logic             other_cmd,
  output logic             locked,
  output logic             frozen
);
  `include "ats_consts.svh"

  ats_pw_if pw ();

  ats_pw_mem u_mem (
    .clock (clock),
    .reset (reset),
    .pw    (pw.mem)
  );

  ats_state_e  state_reg;
  ats_state_e  state_next;
  logic [7:0]  op_reg;
  logic [7:0]  wcnt_reg;
  logic        id_reg;
  logic        lvl_reg;
  logic        cmp_pend_reg;
  ats_word_t   word_d_reg;
  logic        miss_reg;
  logic        frozen_reg;
  logic        locked_reg;
  logic        lock_en_reg;
  logic        level_max_reg;
  logic        user_valid_reg;
  logic        armed_reg;
  logic [2:0]  attempts_reg;
  logic        sec_sup_reg;
  logic        hwr_meta_reg;
  logic        hwr_sync_reg;
  logic        data_req_reg;
  logic        done_reg;
  logic        abort_reg;
  logic        seccnt_wr_reg;
  logic [7:0]  seccnt_val_reg;
  logic        erase_reg;
  logic        wear_reg;
  logic        other_reg;
  logic [31:0] rd_data_reg;
  logic        go;
  logic        handled;
  logic        take_data;
  logic        abort_now;
  logic        word_take;
  logic        pw_word;
  logic        last_word;
  logic        fin;
  logic        fin_ok;
  logic        exhausted;

  // Commands that carry a password sector
  function automatic logic needs_sector(input logic [7:0] op);
    needs_sector = (op == `ATS_OP_SET_PW) || (op == `ATS_OP_UNLOCK) ||
                   (op == `ATS_OP_ERASE);
  endfunction

  // Abort decided before any data is asked for
  function automatic logic early_abort(input logic [7:0] op, input logic frz,
                                       input logic none_left, input logic armed);
    case (op)
      `ATS_OP_SET_PW:  early_abort = frz;
      `ATS_OP_UNLOCK:  early_abort = frz | none_left;
      `ATS_OP_ERASE:   early_abort = frz | none_left | !armed;
      `ATS_OP_DISABLE: early_abort = frz;
      default:         early_abort = 1'b0;
    endcase
  endfunction

  // Hardware reset pin passes two flops before use
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hwr_meta_reg <= 1'b0;
      hwr_sync_reg <= 1'b0;
    end else begin
      hwr_meta_reg <= hw_reset_pin;
      hwr_sync_reg <= hwr_meta_reg;
    end
  end

  // Command decode terms
  assign exhausted = (attempts_reg == 3'h0);
  assign go        = (state_reg == ATS_IDLE) && cmd_valid && !hwr_sync_reg;
  assign abort_now = early_abort(cmd_code, frozen_reg, exhausted, armed_reg);
  assign handled   = sec_sup_reg && ((cmd_code >= `ATS_OP_SET_PW &&
                     cmd_code <= `ATS_OP_FREEZE) ||
                     (cmd_code == `ATS_OP_DISABLE && frozen_reg));
  assign take_data = go && handled && needs_sector(cmd_code) && !abort_now;
  assign word_take = (state_reg == ATS_RECV) && data_valid;
  assign pw_word   = word_take && (wcnt_reg >= `ATS_PW_FIRST) &&
                     (wcnt_reg <= `ATS_PW_LAST);
  assign last_word = word_take && (wcnt_reg == `ATS_SECTOR_LAST);
  assign fin       = (state_reg == ATS_FIN);

  // Set always passes; master unlock refused at maximum level; otherwise all words must match
  assign fin_ok = (op_reg == `ATS_OP_SET_PW) ||
                  (!miss_reg && !(op_reg == `ATS_OP_UNLOCK && id_reg &&
                                  level_max_reg));

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ATS_IDLE: if (take_data) state_next = ATS_RECV;
      ATS_RECV: if (last_word) state_next = ATS_FIN;
      ATS_FIN:  state_next = ATS_IDLE;
      default:  state_next = ATS_IDLE;
    endcase
  end

  // Hardware reset drops any command in flight
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= ATS_IDLE;
    end else if (hwr_sync_reg) begin
      state_reg <= ATS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Sector word counter and control word capture
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      op_reg   <= 8'h00;
      wcnt_reg <= 8'h00;
      id_reg   <= 1'b0;
      lvl_reg  <= 1'b0;
    end else begin
      if (go) begin
        op_reg   <= cmd_code;
        wcnt_reg <= 8'h00;
      end else if (word_take) begin
        wcnt_reg <= wcnt_reg + 8'h01;
      end
      if (word_take && wcnt_reg == 8'h00) begin
        id_reg  <= data_word[`ATS_CW_ID_BIT];
        lvl_reg <= data_word[`ATS_CW_LEVEL_BIT];
      end
    end
  end

  // Password store access: set writes, unlock and erase read the chosen slot
  assign pw.wr_en   = pw_word && (op_reg == `ATS_OP_SET_PW);
  assign pw.wr_sel  = id_reg;
  assign pw.wr_idx  = 4'(wcnt_reg - 8'h01);
  assign pw.wr_data = data_word;
  assign pw.rd_sel  = id_reg;
  assign pw.rd_idx  = 4'(wcnt_reg - 8'h01);

  // Compare one cycle later, since the store answers from a register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cmp_pend_reg <= 1'b0;
      word_d_reg   <= 16'h0000;
      miss_reg     <= 1'b0;
    end else begin
      cmp_pend_reg <= pw_word && (op_reg != `ATS_OP_SET_PW);
      word_d_reg   <= data_word;
      if (go) begin
        miss_reg <= 1'b0;
      end else if (cmp_pend_reg && pw.rd_data != word_d_reg) begin
        miss_reg <= 1'b1;
      end
    end
  end

  // Lock, freeze and attempt state; hardware reset reloads per-session state
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      frozen_reg     <= 1'b0;
      locked_reg     <= 1'b0;
      lock_en_reg    <= 1'b0;
      level_max_reg  <= 1'b0;
      user_valid_reg <= 1'b0;
      armed_reg      <= 1'b0;
      attempts_reg   <= `ATS_ATTEMPTS_INIT;
    end else if (hwr_sync_reg) begin
      frozen_reg   <= 1'b0;
      locked_reg   <= lock_en_reg;
      armed_reg    <= 1'b0;
      attempts_reg <= `ATS_ATTEMPTS_INIT;
    end else begin
      if (go) begin
        armed_reg <= (cmd_code == `ATS_OP_PREPARE);
        if (sec_sup_reg && cmd_code == `ATS_OP_FREEZE) begin
          frozen_reg <= 1'b1;
        end
      end
      if (fin) begin
        unique case (op_reg)
          `ATS_OP_SET_PW: begin
            if (!id_reg) begin           // master set skips lock state
              user_valid_reg <= 1'b1;
              lock_en_reg    <= 1'b1;
              level_max_reg  <= lvl_reg;
            end
          end
          `ATS_OP_UNLOCK: begin
            if (fin_ok) begin
              locked_reg <= 1'b0;
            // A refused master unlock costs no attempt, even when its words miss
            end else if (locked_reg && miss_reg && !(id_reg && level_max_reg) && !exhausted) begin
              attempts_reg <= attempts_reg - 3'h1;
            end
          end
          `ATS_OP_ERASE: begin
            if (fin_ok) begin
              locked_reg     <= 1'b0;
              lock_en_reg    <= 1'b0;
              user_valid_reg <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Completion strobes, all registered
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      data_req_reg   <= 1'b0;
      done_reg       <= 1'b0;
      abort_reg      <= 1'b0;
      seccnt_wr_reg  <= 1'b0;
      seccnt_val_reg <= `ATS_SECCNT_FROZEN;
      erase_reg      <= 1'b0;
      wear_reg       <= 1'b0;
      other_reg      <= 1'b0;
    end else begin
      done_reg      <= (go && handled && !take_data) || fin;
      abort_reg     <= (go && handled && abort_now) || (fin && !fin_ok);
      seccnt_wr_reg <= go && handled && cmd_code == `ATS_OP_FREEZE;
      seccnt_val_reg <= `ATS_SECCNT_FROZEN;
      erase_reg     <= fin && op_reg == `ATS_OP_ERASE && fin_ok;
      wear_reg      <= go && !sec_sup_reg && cmd_code == `ATS_OP_FREEZE;
      other_reg     <= go && !handled && !(!sec_sup_reg &&
                       cmd_code == `ATS_OP_FREEZE);
      if (hwr_sync_reg || last_word) begin
        data_req_reg <= 1'b0;
      end else if (take_data) begin
        data_req_reg <= 1'b1;
      end
    end
  end

  // Register port: control is writable, status reflects the lock state
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sec_sup_reg <= `ATS_CTRL_RESET;
      rd_data_reg <= 32'h0000_0000;
    end else begin
      if (wr_en && addr == `ATS_REG_CTRL) begin
        sec_sup_reg <= wdata[`ATS_CTRL_SUPPORTED_BIT];
      end
      rd_data_reg <= 32'h0000_0000;
      if (rd_en) begin
        unique case (addr)
          `ATS_REG_CTRL: rd_data_reg[`ATS_CTRL_SUPPORTED_BIT] <= sec_sup_reg;
          `ATS_REG_STATUS: begin
            rd_data_reg[`ATS_ST_LOCKED_BIT] <= locked_reg;
            rd_data_reg[`ATS_ST_FROZEN_BIT] <= frozen_reg;
            rd_data_reg[`ATS_ST_LEVEL_BIT]  <= level_max_reg;
            rd_data_reg[`ATS_ST_LOCKEN_BIT] <= lock_en_reg;
            rd_data_reg[`ATS_ST_ATT_LSB +: 3] <= attempts_reg;
            rd_data_reg[`ATS_ST_ARMED_BIT]  <= armed_reg;
            rd_data_reg[`ATS_ST_BUSY_BIT]   <= (state_reg != ATS_IDLE);
            rd_data_reg[`ATS_ST_USERPW_BIT] <= user_valid_reg;
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign rd_data          = rd_data_reg;
  assign data_req         = data_req_reg;
  assign cmd_done         = done_reg;
  assign cmd_abort        = abort_reg;
  assign seccnt_wr        = seccnt_wr_reg;
  assign seccnt_val       = seccnt_val_reg;
  assign erase_start      = erase_reg;
  assign wear_level_start = wear_reg;
  assign other_cmd        = other_reg;
  assign locked           = locked_reg;
  assign frozen           = frozen_reg;

  // Checks on the command outcomes
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_freeze_sets: assert property (
    go && sec_sup_reg && cmd_code == `ATS_OP_FREEZE |=> frozen_reg && cmd_done && !cmd_abort)
    else $error("freeze did not set frozen");
  chk_frozen_holds: assert property (
    frozen_reg && !hwr_sync_reg |=> frozen_reg)
    else $error("frozen cleared without reset");
  chk_frozen_rejects: assert property (
    go && frozen_reg && sec_sup_reg && needs_sector(cmd_code) |=> cmd_abort && cmd_done)
    else $error("frozen device took a lock command");
  chk_seccnt_zero: assert property (
    go && handled && cmd_code == `ATS_OP_FREEZE |=> seccnt_wr && seccnt_val == 8'h00)
    else $error("sector count not zeroed");
  chk_wear_level: assert property (
    go && !sec_sup_reg && cmd_code == `ATS_OP_FREEZE |=> wear_level_start && $stable(frozen_reg))
    else $error("unsupported freeze not sent to wear level");
  chk_prepare_needed: assert property (
    go && sec_sup_reg && cmd_code == `ATS_OP_ERASE && !armed_reg |=> cmd_abort && !data_req)
    else $error("erase ran without prepare");
  chk_count_exhausted: assert property (
    go && sec_sup_reg && exhausted && (cmd_code == `ATS_OP_UNLOCK || cmd_code == `ATS_OP_ERASE)
    |=> cmd_abort)
    else $error("exhausted counter did not abort");
  chk_master_max: assert property (
    fin && op_reg == `ATS_OP_UNLOCK && id_reg && level_max_reg
    |=> cmd_abort && locked_reg == $past(locked_reg) && $stable(attempts_reg))
    else $error("master unlock allowed at maximum");
  chk_attempt_dec: assert property (
    fin && op_reg == `ATS_OP_UNLOCK && miss_reg && !(id_reg && level_max_reg) &&
    locked_reg && !exhausted |=> attempts_reg == $past(attempts_reg) - 3'h1 && cmd_abort)
    else $error("failed unlock did not decrement");
  chk_unlocked_count: assert property (
    fin && op_reg == `ATS_OP_UNLOCK && !locked_reg |=> $stable(attempts_reg))
    else $error("counter moved while unlocked");
  chk_unlock_ok: assert property (
    fin && op_reg == `ATS_OP_UNLOCK && fin_ok |=> !locked_reg && cmd_done && !cmd_abort)
    else $error("good unlock failed");
  chk_erase_ok: assert property (
    fin && op_reg == `ATS_OP_ERASE && fin_ok |=> erase_start && !lock_en_reg && !user_valid_reg)
    else $error("erase did not clear user password");
  chk_master_set: assert property (
    fin && op_reg == `ATS_OP_SET_PW && id_reg |=> $stable(lock_en_reg) && $stable(level_max_reg))
    else $error("master set changed lock state");

  cov_unlock_ok: cover property (fin && op_reg == `ATS_OP_UNLOCK && fin_ok);
  cov_erase_ok: cover property (fin && op_reg == `ATS_OP_ERASE && fin_ok);
  cov_exhausted: cover property (exhausted && locked_reg);
endmodule

// ---- verification/ats_host_model.sv ----
// Host-side model: issues task-file commands and streams password sectors
module ats_host_model (
  input  wire logic        clock,
  input  wire logic        data_req,
  input  wire logic        cmd_done,
  input  wire logic        cmd_abort,
  input  wire logic        other_cmd,
  output logic             cmd_valid,
  output logic      [7:0]  cmd_code,
  output logic             data_valid,
  output logic      [15:0] data_word
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle lines at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    data_valid = 1'b0;
    data_word = 16'h0000;
  end

  // One command, then a full sector while requested; random stalls model a slow host
  task automatic run(input logic [7:0] c, input logic [15:0] w, input logic [15:0] b,
                     input int lim, output logic [1:0] r);
    int k;
    logic dq;
    k = 0;
    dq = 1'b0;
    r = 2'b00;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    for (int n = 0; n < lim && r == 2'b00; n++) begin
      @(posedge clock);
      cmd_valid <= 1'b0;
      cmd_code <= ~c;
      if (dq && k < 256 && $urandom_range(3) != 0) begin
        data_valid <= 1'b1;
        data_word <= (k == 0) ? w : (k < 17) ? b + 16'(k) : ~b;
        k++;
      end else begin
        // Released word never repeats its last value
        data_valid <= 1'b0;
        data_word <= ~data_word;
      end
      #1;
      dq = data_req;
      if (cmd_done) r = {1'b1, cmd_abort};
      else if (other_cmd) r = 2'b01;
    end
  endtask
endmodule

// ---- verification/test_ata_security_lock_state_machine.sv ----
// Self-checking bench for the security lock core
`include "ats_consts.svh"
module test_ata_security_lock_state_machine;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock, reset, hw_reset_pin, cmd_valid, data_valid, wr_en, rd_en;
  logic        data_req, cmd_done, cmd_abort, seccnt_wr, erase_start, wear_level_start;
  logic        other_cmd, locked, frozen, seen_sc, seen_er, seen_wl;
  logic [1:0]  res;
  logic [7:0]  cmd_code, seccnt_val, sc_val;
  logic [7:0]  ops [4];
  logic [15:0] data_word, mp, up, wp;
  logic [3:0]  addr;
  logic [31:0] wdata, rd_data;
  int          miscompares, n_checks, cycles;

  ats_lock_core DUT (.clock(clock), .reset(reset), .hw_reset_pin(hw_reset_pin),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .data_valid(data_valid),
    .data_word(data_word), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .data_req(data_req), .cmd_done(cmd_done), .cmd_abort(cmd_abort),
    .seccnt_wr(seccnt_wr), .seccnt_val(seccnt_val), .erase_start(erase_start),
    .wear_level_start(wear_level_start), .other_cmd(other_cmd), .locked(locked),
    .frozen(frozen));

  ats_host_model host (.clock(clock), .data_req(data_req), .cmd_done(cmd_done),
    .cmd_abort(cmd_abort), .other_cmd(other_cmd), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .data_valid(data_valid), .data_word(data_word));

  // 50 MHz core clock
  initial clock = 1'b0;
  always #10 clock = ~clock;

  // Side pulses rise with cmd_done (wear_level_start without it), before the host returns, so latch them as they rise
  always @(posedge seccnt_wr) begin
    seen_sc = 1'b1;
    sc_val = seccnt_val;
  end
  always @(posedge erase_start) seen_er = 1'b1;
  always @(posedge wear_level_start) seen_wl = 1'b1;

  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk("rd_data", e & m, rd_data & m);
  endtask

  // Expected status word: attempts, lock enable, level, frozen, locked
  function automatic logic [31:0] st(input logic [2:0] a, input logic e, l, f, k);
    return {25'h0, a, e, l, f, k};
  endfunction

  task automatic sc(input logic [2:0] a, input logic e, l, f, k);
    rd(`ATS_REG_STATUS, st(a, e, l, f, k), 32'h0000007F);
    chk("locked", {31'h0, k}, {31'h0, locked});
    chk("frozen", {31'h0, f}, {31'h0, frozen});
  endtask

  task automatic go(input logic [7:0] c, input logic [15:0] w, input logic [15:0] b,
                    input logic [1:0] e);
    seen_sc = 1'b0;
    seen_er = 1'b0;
    seen_wl = 1'b0;
    host.run(c, w, b, 2000, res);
    chk("cmd_result", {30'h0, e}, {30'h0, res});
  endtask

  // Hardware reset pin, long enough for its synchroniser both ways
  task automatic hwrst();
    @(posedge clock);
    hw_reset_pin <= 1'b1;
    repeat (4) @(posedge clock);
    hw_reset_pin <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  // Main sequence: passwords, unlock budget, erase, freeze, unsupported mode
  initial begin
    reset = 1'b1;
    hw_reset_pin = 1'b0;
    addr = 4'h0;
    wdata = 32'h00000000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ops = '{`ATS_OP_SET_PW, `ATS_OP_UNLOCK, `ATS_OP_ERASE, `ATS_OP_DISABLE};
    void'($urandom(32'hC5F8C3F8));
    mp = 16'($urandom);
    up = mp ^ 16'h5A3C;
    wp = ~up;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rd(`ATS_REG_CTRL, 32'h00000001, 32'h00000001);
    rd(4'h8, 32'h00000000, 32'hFFFFFFFF);
    sc(3'h5, 0, 0, 0, 0);
    go(`ATS_OP_SET_PW, 16'h0101, mp, 2'b10);
    sc(3'h5, 0, 0, 0, 0);
    go(`ATS_OP_SET_PW, 16'h0000, up, 2'b10);
    sc(3'h5, 1, 0, 0, 0);
    hwrst();
    sc(3'h5, 1, 0, 0, 1);
    go(`ATS_OP_UNLOCK, 16'h0000, wp, 2'b11);
    sc(3'h4, 1, 0, 0, 1);
    go(`ATS_OP_UNLOCK, 16'h0001, mp, 2'b10);
    sc(3'h4, 1, 0, 0, 0);
    go(`ATS_OP_UNLOCK, 16'h0000, wp, 2'b11);
    sc(3'h4, 1, 0, 0, 0);
    go(`ATS_OP_SET_PW, 16'h0100, up, 2'b10);
    hwrst();
    sc(3'h5, 1, 1, 0, 1);
    go(`ATS_OP_UNLOCK, 16'h0001, mp, 2'b11);
    chk("locked", 32'h1, {31'h0, locked});
    sc(3'h5, 1, 1, 0, 1);
    hwrst();
    repeat (5) go(`ATS_OP_UNLOCK, 16'h0000, wp, 2'b11);
    sc(3'h0, 1, 1, 0, 1);
    go(`ATS_OP_UNLOCK, 16'h0000, up, 2'b11);
    go(`ATS_OP_PREPARE, 16'h0000, up, 2'b10);
    go(`ATS_OP_ERASE, 16'h0000, up, 2'b11);
    hwrst();
    sc(3'h5, 1, 1, 0, 1);
    go(`ATS_OP_ERASE, 16'h0000, up, 2'b11);
    go(`ATS_OP_PREPARE, 16'h0000, up, 2'b10);
    go(`ATS_OP_ERASE, 16'h0000, wp, 2'b11);
    go(`ATS_OP_PREPARE, 16'h0000, up, 2'b10);
    go(`ATS_OP_ERASE, 16'h0000, up, 2'b10);
    chk("erase_start", 32'h1, {31'h0, seen_er});
    rd(`ATS_REG_STATUS, 32'h0, 32'h00000201);
    go(`ATS_OP_FREEZE, 16'h0000, up, 2'b10);
    chk("seccnt", 32'h100, {23'h0, seen_sc, sc_val});
    go(`ATS_OP_FREEZE, 16'h0000, up, 2'b10);
    chk("frozen", 32'h1, {31'h0, frozen});
    foreach (ops[i]) go(ops[i], 16'h0000, up, 2'b11);
    chk("frozen", 32'h1, {31'h0, frozen});
    hwrst();
    chk("frozen", 32'h0, {31'h0, frozen});
    wr(`ATS_REG_CTRL, 32'h00000000);
    seen_wl = 1'b0;
    host.run(`ATS_OP_FREEZE, 16'h0000, up, 6, res);
    chk("wear_level", 32'h1, {31'h0, seen_wl});
    chk("frozen", 32'h0, {31'h0, frozen});
    chk("cmd_result", 32'h0, {30'h0, res});
    go(`ATS_OP_SET_PW, 16'h0000, up, 2'b01);
    wr(`ATS_REG_CTRL, 32'h00000001);
    go(`ATS_OP_DISABLE, 16'h0000, up, 2'b01);
    conclude();
  end
endmodule
